// >>> src/charger_pkg.sv
/*
  Package for the charger status and power selector block.
  Holds register offsets, status bit positions, the control reset value and the
  states of the thermal supervisor.
  Assumes a single 200 MHz clock and synchronous comparator inputs.
*/
// Overview of operation
// - Status bit 7 shows adapter drives system
// - Connect adapter when detected and learn clear
// - Learn cycle plus depleted battery selects adapter
// - Adapter overcurrent drops adapter switch drive on the next clock edge
// - Status bit 8 shows thermal shutdown active
// - Above 145C: charger off, alarm raised
// - Register port works during thermal shutdown
// - Restart charging automatically below 130C
// - Status bit 9 cold, charging withheld
// - Status bit 10 hot, charging withheld
// - Hot uses start or operating threshold
// - Battery connects when no adapter, or when learning with battery not depleted
package charger_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] status_offset  = 8'h00;  // Read-only status
  localparam logic [7:0] control_offset = 8'h04;  // Read/write control
  localparam logic [7:0] alarm_offset   = 8'h08;  // Alarm, write one to clear

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int battery_conn_bit  = 6;
  localparam int adapter_conn_bit  = 7;
  localparam int thermal_fault_bit = 8;
  localparam int pack_cold_bit     = 9;
  localparam int pack_hot_bit      = 10;
  localparam int batt_low_bit      = 11;
  localparam int charging_bit      = 0;

  // ****************************************************************
  // Control field positions and reset value
  // ****************************************************************
  localparam int learn_cycle_bit   = 4;
  localparam int charge_enable_bit = 0;
  localparam logic [15:0] control_reset = 16'h0001;

  // ****************************************************************
  // Thermal supervisor states
  // ****************************************************************
  typedef enum logic [0:0] {
    thermal_ok   = 1'b0,
    thermal_shut = 1'b1
  } thermal_state_t;

endpackage

// >>> src/charger_status_if.sv
/*
  Interface carrying comparator levels between the top and the
  selector. Assumes all levels synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface charger_status_if;
  logic adapter_present;     // Adapter detect above threshold
  logic learn_cycle;         // Learn cycle setting
  logic battery_depleted;    // Battery below depleted threshold
  logic adapter_overcurrent; // Adapter overcurrent comparator
  logic adapter_on;          // Adapter switch decision
  logic battery_on;          // Battery switch decision
  modport top (output adapter_present, learn_cycle, battery_depleted, adapter_overcurrent,
               input adapter_on, battery_on);
  modport sel (input adapter_present, learn_cycle, battery_depleted, adapter_overcurrent,
               output adapter_on, battery_on);
endinterface
`default_nettype wire

// >>> src/power_selector.sv
/*
  Adapter and battery to system power selector.
  Assumes comparator levels arrive synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module power_selector
  import charger_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  charger_status_if.sel   sel_if
);

  // ****************************************************************
  // Selection
  // ****************************************************************
  logic adapter_want; // Adapter should drive system

  // Decide adapter path
  always_comb begin
    adapter_want = sel_if.adapter_present &&
                   (!sel_if.learn_cycle || sel_if.battery_depleted);
  end

  // Drive adapter switch, overcurrent removes it the same cycle
  assign sel_if.adapter_on = adapter_want && !sel_if.adapter_overcurrent;

  // Battery path, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sel_if.battery_on <= 1'b1;
    end else begin
      sel_if.battery_on <= !sel_if.adapter_present ||
                           (sel_if.learn_cycle && !sel_if.battery_depleted);
    end
  end

endmodule
`default_nettype wire

// >>> src/charger_status_power_selector.sv
/*
  Status flags and supervisory logic of a battery charger.
  Assumes synchronous comparator inputs and a simple strobe register port.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_status_power_selector
  import charger_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  input  wire logic        adapter_detect_input,
  input  wire logic        battery_depleted_threshold,
  input  wire logic        adapter_overcurrent,
  input  wire logic        die_over_145,
  input  wire logic        die_below_130,
  input  wire logic        ts_cold,
  input  wire logic        ts_hot_start,
  input  wire logic        ts_hot_operating,
  output logic             adapter_switch_drive,
  output logic             battery_switch_drive,
  output logic             charge_enable,
  output logic             alarm
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0]    control_reg;    // Host control
  logic           alarm_reg;      // Sticky thermal alarm
  thermal_state_t thermal_reg;    // Thermal supervisor
  logic           charging_reg;   // Charger running
  logic           pack_hot;       // Hot with active threshold
  logic           charge_ok;      // All conditions allow charge
  logic [15:0]    status_word;    // Live status
  charger_status_if sel_if ();    // To selector

  // Feed selector
  assign sel_if.adapter_present     = adapter_detect_input;
  assign sel_if.learn_cycle         = control_reg[learn_cycle_bit];
  assign sel_if.battery_depleted    = battery_depleted_threshold;
  assign sel_if.adapter_overcurrent = adapter_overcurrent;

  power_selector u_sel (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .sel_if  (sel_if)
  );

  // Hot threshold depends on charging state
  always_comb begin
    pack_hot = charging_reg ? ts_hot_operating : ts_hot_start;
    charge_ok = control_reg[charge_enable_bit] && adapter_detect_input &&
                (thermal_reg == thermal_ok) && !ts_cold && !pack_hot;
  end

  // Live status word, nothing latched
  always_comb begin
    status_word = 16'h0000;
    status_word[charging_bit]      = charging_reg;
    status_word[battery_conn_bit]  = battery_switch_drive;
    status_word[adapter_conn_bit]  = adapter_switch_drive;
    status_word[thermal_fault_bit] = (thermal_reg == thermal_shut);
    status_word[pack_cold_bit]     = ts_cold;
    status_word[pack_hot_bit]      = pack_hot;
    status_word[batt_low_bit]      = battery_depleted_threshold;
  end

  // ****************************************************************
  // Thermal supervisor
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      thermal_reg <= thermal_ok;
    end else begin
      case (thermal_reg)
        thermal_ok: begin
          if (die_over_145) begin
            thermal_reg <= thermal_shut;
          end
        end
        thermal_shut: begin
          if (die_below_130) begin
            thermal_reg <= thermal_ok;
          end
        end
        default: thermal_reg <= thermal_ok;
      endcase
    end
  end

  // Charger run state, restarts without host
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      charging_reg <= 1'b0;
    end else begin
      charging_reg <= charge_ok;
    end
  end

  // Alarm: set on shutdown entry, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      alarm_reg <= 1'b0;
    end else if (thermal_reg == thermal_ok && die_over_145) begin
      alarm_reg <= 1'b1;
    end else if (reg_write && reg_addr == alarm_offset && reg_wdata[0]) begin
      alarm_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Register port, independent of thermal state
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      control_reg <= control_reset;
    end else if (reg_write && reg_addr == control_offset) begin
      control_reg <= reg_wdata;
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read && reg_addr == status_offset) begin
      reg_rdata <= status_word;
    end else if (reg_read && reg_addr == control_offset) begin
      reg_rdata <= control_reg;
    end else if (reg_read && reg_addr == alarm_offset) begin
      reg_rdata <= {15'h0000, alarm_reg};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      adapter_switch_drive <= 1'b0;
      battery_switch_drive <= 1'b1;
      charge_enable        <= 1'b0;
      alarm                <= 1'b0;
    end else begin
      adapter_switch_drive <= sel_if.adapter_on && !adapter_overcurrent;
      battery_switch_drive <= sel_if.battery_on;
      charge_enable        <= charge_ok;
      alarm                <= alarm_reg;
    end
  end

endmodule
`default_nettype wire

// >>> dv/charger_status_power_selector_properties.sv
/* Assertions on the top ports of the charger status block.
   Assumes one clock and a bind onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module charger_checker
  import charger_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        adapter_detect_input,
  input wire logic        adapter_overcurrent,
  input wire logic        die_over_145,
  input wire logic        ts_cold,
  input wire logic        ts_hot_start,
  input wire logic        ts_hot_operating,
  input wire logic        adapter_switch_drive,
  input wire logic        battery_switch_drive,
  input wire logic        charge_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ****************************************************************
  // Properties
  // ****************************************************************
  ovc_drops_adapter_a: assert property (adapter_overcurrent |=> !adapter_switch_drive)
    else $error("adapter switch on during overcurrent");
  no_adapter_off_a: assert property (!adapter_detect_input |=> !adapter_switch_drive && !charge_enable)
    else $error("adapter switch on without adapter");
  battery_fallback_a: assert property (!adapter_detect_input |-> ##2 battery_switch_drive)
    else $error("battery not connected without adapter");
  thermal_stop_a: assert property (die_over_145 |-> ##2 !charge_enable)
    else $error("charger running after overtemperature");
  cold_hold_a: assert property (ts_cold |=> !charge_enable)
    else $error("charging while pack cold");
  hot_operating_a: assert property (charge_enable && ts_hot_operating |=> !charge_enable)
    else $error("charging while pack hot");
  hot_start_a: assert property (!charge_enable && ts_hot_start |=> !charge_enable)
    else $error("charging started above start threshold");
  status_adapter_a: assert property (reg_read && reg_addr == status_offset |=>
    reg_rdata[adapter_conn_bit] == $past(adapter_switch_drive)) else $error("adapter status bit wrong");
  // Main scenarios reached
  cover property ($rose(charge_enable));
  cover property (die_over_145 ##2 !charge_enable);
  cover property (adapter_overcurrent && adapter_detect_input);
endmodule
bind charger_status_power_selector charger_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .adapter_detect_input(adapter_detect_input),
  .adapter_overcurrent(adapter_overcurrent), .die_over_145(die_over_145), .ts_cold(ts_cold),
  .ts_hot_start(ts_hot_start), .ts_hot_operating(ts_hot_operating), .charge_enable(charge_enable),
  .adapter_switch_drive(adapter_switch_drive), .battery_switch_drive(battery_switch_drive));
`default_nettype wire

// >>> dv/host_model.sv
/* Host model driving the register port.
   Assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        ref_clk,
  output var  logic [7:0]  reg_addr,
  output var  logic [15:0] reg_wdata,
  output var  logic        reg_write,
  output var  logic        reg_read,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00; reg_wdata = 16'h0000; reg_write = 1'b0; reg_read = 1'b0;
  end
  // One-cycle write strobe
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1; end
    @(posedge ref_clk) reg_write <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk) begin reg_addr <= a; reg_read <= 1'b1; end
    @(posedge ref_clk) reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// >>> dv/charger_status_power_selector_bench.sv
/* Self-checking bench of the charger status block.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module charger_status_power_selector_bench;
  import charger_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, ad = 1'b0, dep = 1'b0, ovc = 1'b0, hot = 1'b0, cold = 1'b0;
  logic over = 1'b0, below = 1'b0, hs = 1'b0, ho = 1'b0, learn, ae, be, ce, al, wr, rd;
  logic [7:0]  addr;
  logic [15:0] wd, rdat, s;
  int errors = 0, total_checks = 0, seed = 61600, r;
  initial forever #2.5 ref_clk = ~ref_clk;
  host_model i_host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wdata(wd), .reg_write(wr), .reg_read(rd),
    .reg_rdata(rdat));
  charger_status_power_selector i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wd),
    .reg_write(wr), .reg_read(rd), .reg_rdata(rdat), .adapter_detect_input(ad), .battery_depleted_threshold(dep),
    .adapter_overcurrent(ovc), .die_over_145(over), .die_below_130(below), .ts_cold(cold), .ts_hot_start(hs),
    .ts_hot_operating(ho), .adapter_switch_drive(ae), .battery_switch_drive(be), .charge_enable(ce), .alarm(al));
  // Expected switch states
  function automatic logic exp_adapter(logic a, l, d, o);
    return a && (!l || d) && !o;
  endfunction
  function automatic logic exp_battery(logic a, l, d);
    return !a || (l && !d);
  endfunction
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Selector: corner cases first, then random
    for (int i = 0; i < 24; i++) begin
      r = (i == 0) ? 32'h13 : (i == 1) ? 32'h0D : $random(seed);
      learn = r[4];
      i_host.write_reg(control_offset, {11'h000, learn, 4'h1});
      @(posedge ref_clk) begin ad <= r[0]; dep <= r[1]; ovc <= r[2] & r[3]; end
      settle();
      `CHK("adapter", exp_adapter(ad, learn, dep, ovc), ae)
      `CHK("battery", exp_battery(ad, learn, dep), be)
      i_host.read_reg(status_offset, s);
      `CHK("st7", exp_adapter(ad, learn, dep, ovc), s[adapter_conn_bit])
    end
    i_host.write_reg(control_offset, 16'h0001);
    @(posedge ref_clk) begin ad <= 1'b1; ovc <= 1'b0; hs <= 1'b1; end
    settle();
    `CHK("hot start", 1'b0, ce)
    i_host.read_reg(status_offset, s);
    `CHK("st10", 1'b1, s[pack_hot_bit])
    @(posedge ref_clk) hs <= 1'b0;
    settle();
    `CHK("charge", 1'b1, ce)
    @(posedge ref_clk) hs <= 1'b1;
    settle();
    `CHK("charge op", 1'b1, ce)
    @(posedge ref_clk) ho <= 1'b1;
    settle();
    `CHK("hot op", 1'b0, ce)
    @(posedge ref_clk) begin hs <= 1'b0; ho <= 1'b0; cold <= 1'b1; end
    i_host.read_reg(status_offset, s);
    `CHK("st9", 1'b1, s[pack_cold_bit])
    @(posedge ref_clk) cold <= 1'b0;
    // Thermal shutdown and automatic restart
    @(posedge ref_clk) over <= 1'b1;
    @(posedge ref_clk) over <= 1'b0;
    settle();
    `CHK("shut", 1'b0, ce)
    `CHK("alarm", 1'b1, al)
    i_host.read_reg(status_offset, s);
    `CHK("st8", 1'b1, s[thermal_fault_bit])
    `CHK("st9 low", 1'b0, s[pack_cold_bit])
    @(posedge ref_clk) below <= 1'b1;
    settle();
    `CHK("restart", 1'b1, ce)
    i_host.read_reg(status_offset, s);
    `CHK("st8 low", 1'b0, s[thermal_fault_bit])
    `CHK("st11", dep, s[batt_low_bit])
    // Sticky alarm stays until the host clears it
    i_host.read_reg(alarm_offset, s);
    `CHK("alarm reg", 16'h0001, s)
    i_host.write_reg(alarm_offset, 16'h0001);
    settle();
    `CHK("alarm clr", 1'b0, al)
    i_host.read_reg(control_offset, s);
    `CHK("control", 16'h0001, s)
    i_host.read_reg(8'h0C, s);
    `CHK("unmapped", 16'h0000, s)
    finish_test();
  end
endmodule
`default_nettype wire
